// ==== rtl/wwd_pkg.sv ====
// package: register map, field positions, reset values and counts of the windowed watchdog
package wwd_pkg;

  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  OFS_CTRL       = 5'h00;
  localparam logic [4:0]  OFS_RELOAD     = 5'h04;
  localparam logic [4:0]  OFS_WINDOW     = 5'h08;
  localparam logic [4:0]  OFS_SERVICE    = 5'h0C;
  localparam logic [4:0]  OFS_COUNT      = 5'h10;
  localparam logic [4:0]  OFS_STATUS     = 5'h14;
  localparam logic [4:0]  OFS_MASK       = 5'h18;
  localparam logic [4:0]  OFS_PREWARN    = 5'h1C;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int          CTRL_ENABLE    = 0;
  localparam int          CTRL_DIVSEL    = 1;
  localparam int          CTRL_WINEN     = 2;
  localparam int          STAT_OVERFLOW  = 0;
  localparam int          STAT_INVALID   = 1;
  localparam int          STAT_PREWARN   = 2;
  localparam int          STAT_SYSRESET  = 3;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam logic [7:0]  RELOAD_RESET   = 8'h00;
  localparam logic [7:0]  WINDOW_RESET   = 8'h00;
  localparam logic [1:0]  MASK_RESET     = 2'h0;
  localparam logic [31:0] RDATA_NONE     = 32'h0000_0000;

  // ==========================================================================
  // counts
  // ==========================================================================
  localparam logic [15:0] COUNT_TOP      = 16'hFFFF;
  localparam logic [7:0]  LOW_BYTE_ZERO  = 8'h00;
  localparam logic [5:0]  PREWARN_TICKS  = 6'h30;
  localparam logic [5:0]  PREWARN_LAST   = PREWARN_TICKS - 6'h01;
  localparam logic [6:0]  DIV_FAST_LAST  = 7'h01;  // peripheral clock / 2
  localparam logic [6:0]  DIV_SLOW_LAST  = 7'h7F;  // peripheral clock / 128

  // ==========================================================================
  // watchdog states
  // ==========================================================================
  typedef enum logic [3:0] {
    WWD_IDLE    = 4'b0001,
    WWD_COUNT   = 4'b0010,
    WWD_PREWARN = 4'b0100,
    WWD_RESET   = 4'b1000
  } wwd_state_type;

endpackage : wwd_pkg

// ==== rtl/wwd_prescaler.sv ====
// module: input clock divider of the watchdog, one tick per 2 or 128 clocks
`timescale 1ns/1ps
module wwd_prescaler
  import wwd_pkg::*;
(
  input  logic CORE_CLK,
  input  logic ARST_N,
  input  logic DIV_SELECT,
  input  logic RESTART,
  output logic TICK
);

  logic [6:0] div_cnt;
  logic [6:0] next_div_cnt;
  logic [6:0] div_last;

  // ==========================================================================
  // divider
  // ==========================================================================
  // restart keeps the service-to-overflow time exact, not short by a fraction
  always_comb begin
    div_last     = DIV_SELECT ? DIV_SLOW_LAST : DIV_FAST_LAST;  // RULE6
    TICK         = (div_cnt >= div_last) && !RESTART;
    next_div_cnt = div_cnt + 7'h01;
    if (RESTART || TICK) begin
      next_div_cnt = 7'h00;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

endmodule : wwd_prescaler

// ==== rtl/wwd_top.sv ====
// module: windowed watchdog timer with Avalon-MM register slave and interrupt
//
// Functional notes
// RULE1: unserviced overflow raises NMI and enters prewarning
// RULE2: prewarning lasts 30h ticks, then system reset
// RULE3: refresh inside window: prewarning, no NMI
// RULE4: window spans 0000h to window byte, 00h
// RULE5: valid service reloads reload byte times 256
// RULE6: tick is clock divided by 2 or 128
// RULE7: software writes reload byte to set period
// RULE8: period is divider times (65536 - reload*256)
// RULE9: window byte above reload shortens usable period
// RULE10: software keeps window byte not below reload
// RULE11: refreshes ignored once prewarning has started
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module wwd_top
  import wwd_pkg::*;
(
  input  logic        CORE_CLK,
  input  logic        ARST_N,
  input  logic [4:0]  AVS_ADDRESS,
  input  logic        AVS_READ,
  input  logic        AVS_WRITE,
  input  logic [31:0] AVS_WRITEDATA,
  input  logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic        AVS_WAITREQUEST,
  output logic        IRQ,
  output logic        WATCHDOG_NMI_REQUEST,
  output logic        WATCHDOG_SYSTEM_RESET
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  wwd_state_type state;
  wwd_state_type next_state;

  logic [15:0] watchdog_counter;
  logic [15:0] next_watchdog_counter;
  logic [5:0]  prewarn_cnt;
  logic [5:0]  next_prewarn_cnt;
  logic        nmi;
  logic        next_nmi;
  logic        sysrst;
  logic        next_sysrst;

  logic [2:0]  ctrl;
  logic [2:0]  next_ctrl;
  logic [7:0]  reload_high_byte;
  logic [7:0]  next_reload_high_byte;
  logic [7:0]  window_boundary_byte;
  logic [7:0]  next_window_boundary_byte;
  logic [1:0]  status;
  logic [1:0]  next_status;
  logic [1:0]  mask;
  logic [1:0]  next_mask;

  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  logic        bus_req;
  logic        wr_commit;
  logic        rd_capture;
  logic        wr_lane0;
  logic        service_req;
  logic        tick;
  logic        pres_restart;
  logic        evt_overflow;
  logic        evt_invalid;
  logic        locked;
  logic        input_divider_select;

  // ==========================================================================
  // functions
  // ==========================================================================
  // counter value at which the watchdog restarts after a valid service
  function automatic logic [15:0] reload_point(input logic [7:0] hi);
    reload_point = {hi, LOW_BYTE_ZERO};  // RULE5
  endfunction : reload_point

  // true while a refresh would land inside the forbidden window
  function automatic logic in_window(input logic [15:0] cnt,
                                     input logic [7:0]  win);
    in_window = (cnt <= {win, LOW_BYTE_ZERO});  // RULE4
  endfunction : in_window

  // address match against one register offset; callers gate it with wr_lane0
  function automatic logic hit(input logic [4:0] addr,
                               input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ==========================================================================
  // divider instance
  // ==========================================================================
  assign input_divider_select = ctrl[CTRL_DIVSEL];

  wwd_prescaler u_prescaler (
    .CORE_CLK   (CORE_CLK),
    .ARST_N     (ARST_N),
    .DIV_SELECT (input_divider_select),
    .RESTART    (pres_restart),
    .TICK       (tick)
  );

  // ==========================================================================
  // bus handshake
  // ==========================================================================
  // every access takes two edges: capture, then answer with waitrequest low
  // only byte lane 0 gates a write: every field sits in the low bytes
  // a request right after the answer waits one cycle again, like the first
  always_comb begin
    bus_req         = AVS_READ || AVS_WRITE;
    AVS_WAITREQUEST = bus_req && !ack;
    wr_commit       = AVS_WRITE && ack;
    rd_capture      = AVS_READ && !ack;
    wr_lane0        = wr_commit && AVS_BYTEENABLE[0];
    next_ack        = bus_req && !ack;
    service_req     = wr_lane0 && hit(AVS_ADDRESS, OFS_SERVICE);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  // ==========================================================================
  // watchdog sequence
  // ==========================================================================
  // once prewarning starts software can neither stop nor refresh the timer
  always_comb begin
    locked = (state == WWD_PREWARN) || (state == WWD_RESET);  // RULE11
  end

  // next state, counter, prewarning count and both watchdog outputs
  // the counter stands still in prewarning; only prewarn_cnt advances
  always_comb begin
    next_state            = state;
    next_watchdog_counter = watchdog_counter;
    next_prewarn_cnt      = prewarn_cnt;
    next_nmi              = nmi;
    next_sysrst           = sysrst;
    pres_restart          = 1'b0;
    evt_overflow          = 1'b0;
    evt_invalid           = 1'b0;
    case (state)
      WWD_IDLE: begin
        if (ctrl[CTRL_ENABLE]) begin
          next_watchdog_counter = reload_point(reload_high_byte);
          pres_restart          = 1'b1;
          next_state            = WWD_COUNT;
        end
      end
      WWD_COUNT: begin
        if (!ctrl[CTRL_ENABLE]) begin
          next_state = WWD_IDLE;
        end else if (service_req) begin
          pres_restart = 1'b1;
          // boundary inclusive: a count equal to {window,00} is still early
          if (ctrl[CTRL_WINEN] && in_window(watchdog_counter, window_boundary_byte)) begin
            // early refresh: prewarning without the NMI
            next_prewarn_cnt = 6'h00;  // RULE3
            evt_invalid      = 1'b1;  // RULE3
            next_state       = WWD_PREWARN;  // RULE3
          end else begin
            // window above reload leaves only the tail as usable period
            next_watchdog_counter = reload_point(reload_high_byte);  // RULE5 RULE9
          end
        end else if (tick) begin
          if (watchdog_counter == COUNT_TOP) begin
            next_nmi         = 1'b1;  // RULE1
            evt_overflow     = 1'b1;  // RULE1
            next_prewarn_cnt = 6'h00;
            next_state       = WWD_PREWARN;  // RULE1
          end else begin
            // from reload point, overflow comes after 65536-reload*256 ticks
            next_watchdog_counter = watchdog_counter + 16'h0001;  // RULE8
          end
        end
      end
      WWD_PREWARN: begin
        if (tick) begin
          if (prewarn_cnt == PREWARN_LAST) begin
            next_sysrst = 1'b1;  // RULE2
            next_state  = WWD_RESET;  // RULE2
          end else begin
            next_prewarn_cnt = prewarn_cnt + 6'h01;  // RULE2
          end
        end
      end
      WWD_RESET: begin
        // held until the system reset comes back on ARST_N
        // software has no way out here: a due reset cannot be cancelled
        next_sysrst = 1'b1;
      end
      default: begin
        next_state = WWD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state            <= WWD_IDLE;
      watchdog_counter <= 16'h0000;
      prewarn_cnt      <= 6'h00;
      nmi              <= 1'b0;
      sysrst           <= 1'b0;
    end else begin
      state            <= next_state;
      watchdog_counter <= next_watchdog_counter;
      prewarn_cnt      <= next_prewarn_cnt;
      nmi              <= next_nmi;
      sysrst           <= next_sysrst;
    end
  end

  // ==========================================================================
  // register writes
  // ==========================================================================
  // reload byte sets the period; new value applies at next service
  // enable is frozen once prewarning runs; reload and window stay writable
  always_comb begin
    next_ctrl                 = ctrl;
    next_reload_high_byte     = reload_high_byte;
    next_window_boundary_byte = window_boundary_byte;
    next_mask                 = mask;
    if (wr_lane0) begin
      if (hit(AVS_ADDRESS, OFS_CTRL) && !locked) begin
        next_ctrl = AVS_WRITEDATA[2:0];  // RULE11
      end
      if (hit(AVS_ADDRESS, OFS_RELOAD)) begin
        next_reload_high_byte = AVS_WRITEDATA[7:0];  // RULE7
      end
      if (hit(AVS_ADDRESS, OFS_WINDOW)) begin
        next_window_boundary_byte = AVS_WRITEDATA[7:0];  // RULE10
      end
      if (hit(AVS_ADDRESS, OFS_MASK)) begin
        next_mask = AVS_WRITEDATA[1:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl                 <= CTRL_RESET;
      reload_high_byte     <= RELOAD_RESET;
      window_boundary_byte <= WINDOW_RESET;
      mask                 <= MASK_RESET;
    end else begin
      ctrl                 <= next_ctrl;
      reload_high_byte     <= next_reload_high_byte;
      window_boundary_byte <= next_window_boundary_byte;
      mask                 <= next_mask;
    end
  end

  // ==========================================================================
  // sticky status and interrupt
  // ==========================================================================
  // a new event in the clearing cycle wins, so none is lost
  // bits 2 and 3 of the status word are live state, not stored here
  always_comb begin
    next_status = status;
    if (wr_lane0 && hit(AVS_ADDRESS, OFS_STATUS)) begin
      next_status = status & ~AVS_WRITEDATA[1:0];
    end
    if (evt_overflow) begin
      next_status[STAT_OVERFLOW] = 1'b1;
    end
    if (evt_invalid) begin
      next_status[STAT_INVALID] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= 2'h0;
    end else begin
      status <= next_status;
    end
  end

  // ==========================================================================
  // read data
  // ==========================================================================
  // captured at the first edge, presented while waitrequest is low
  always_comb begin
    next_rdata = rdata;
    if (rd_capture) begin
      case (AVS_ADDRESS)
        OFS_CTRL: begin
          next_rdata = {29'h000_0000, ctrl};
        end
        OFS_RELOAD: begin
          next_rdata = {24'h00_0000, reload_high_byte};
        end
        OFS_WINDOW: begin
          next_rdata = {24'h00_0000, window_boundary_byte};
        end
        OFS_COUNT: begin
          next_rdata = {16'h0000, watchdog_counter};
        end
        // bit3 reset out, bit2 locked, bits 1:0 sticky events
        OFS_STATUS: begin
          next_rdata = {28'h000_0000, sysrst, locked, status};
        end
        OFS_MASK: begin
          next_rdata = {30'h000_0000, mask};
        end
        OFS_PREWARN: begin
          next_rdata = {26'h00_0000, prewarn_cnt};
        end
        default: begin
          next_rdata = RDATA_NONE;  // service and unmapped read zero
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata <= RDATA_NONE;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // irq follows the registers directly, so a clear drops it at the same edge as the status bit
  assign AVS_READDATA          = rdata;
  assign IRQ                   = |(status & mask);
  assign WATCHDOG_NMI_REQUEST  = nmi;
  assign WATCHDOG_SYSTEM_RESET = sysrst;

endmodule : wwd_top

// ==== tb/wwd_properties.sv ====
// checker: port-level properties of the windowed watchdog
`timescale 1ns/1ps
module wwd_properties
  import wwd_pkg::*;
(
  input logic        CORE_CLK,
  input logic        ARST_N,
  input logic [4:0]  AVS_ADDRESS,
  input logic        AVS_READ,
  input logic        AVS_WRITE,
  input logic [31:0] AVS_WRITEDATA,
  input logic [3:0]  AVS_BYTEENABLE,
  input logic [31:0] AVS_READDATA,
  input logic        AVS_WAITREQUEST,
  input logic        IRQ,
  input logic        WATCHDOG_NMI_REQUEST,
  input logic        WATCHDOG_SYSTEM_RESET
);
  logic        div_slow;
  logic [15:0] pw_cnt;
  logic [15:0] pw_nom;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // ==========================================================================
  // helper logic
  // ==========================================================================
  // shadow of the divider bit; ctrl writes are ignored while nmi or system reset is raised
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_slow <= 1'b0;
      pw_cnt   <= 16'h0000;
    end else begin
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CTRL && AVS_BYTEENABLE[0]
          && !WATCHDOG_NMI_REQUEST && !WATCHDOG_SYSTEM_RESET) begin
        div_slow <= AVS_WRITEDATA[CTRL_DIVSEL];
      end
      pw_cnt <= WATCHDOG_NMI_REQUEST ? pw_cnt + 16'h0001 : 16'h0000;
    end
  end
  // nominal prewarning length in clocks: 30h ticks of 2 or 128 clocks
  assign pw_nom = div_slow ? 16'h1800 : 16'h0060;

  // ==========================================================================
  // sequences and properties
  // ==========================================================================
  sequence s_req_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_reset_quiet;
    !WATCHDOG_SYSTEM_RESET [*8];
  endsequence

  property p_wait_answer;
    s_req_wait |=> !AVS_WAITREQUEST;
  endproperty
  property p_wait_idle;
    !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST;
  endproperty
  property p_unmapped_read;
    s_req_wait ##0 (AVS_READ && AVS_ADDRESS[1:0] != 2'b00) |=> AVS_READDATA == RDATA_NONE;
  endproperty
  property p_rdata_stable;
    !(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA);
  endproperty
  property p_nmi_hold;
    WATCHDOG_NMI_REQUEST |=> WATCHDOG_NMI_REQUEST;
  endproperty
  property p_nmi_before_reset;
    $rose(WATCHDOG_NMI_REQUEST) |-> s_reset_quiet;
  endproperty
  property p_prewarn_len;
    $rose(WATCHDOG_SYSTEM_RESET) && WATCHDOG_NMI_REQUEST
      |-> pw_cnt + 16'h0002 >= pw_nom && pw_cnt <= pw_nom + 16'h0003;
  endproperty
  property p_reset_hold;
    WATCHDOG_SYSTEM_RESET |=> WATCHDOG_SYSTEM_RESET;
  endproperty
  property p_irq_cause;
    $rose(IRQ) |-> WATCHDOG_NMI_REQUEST || $past(AVS_WRITE) || $past(AVS_WRITE, 2);
  endproperty

  a_wait_answer: assert property (p_wait_answer) else $error("waitrequest held too long");
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without request");
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
  a_rdata_stable: assert property (p_rdata_stable) else $error("readdata moved unasked");
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi request dropped");
  a_nmi_before_reset: assert property (p_nmi_before_reset) else $error("reset too soon");
  a_prewarn_len: assert property (p_prewarn_len) else $error("prewarning length off");
  a_reset_hold: assert property (p_reset_hold) else $error("system reset dropped");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule : wwd_properties

bind wwd_top wwd_properties wwd_properties_i (
  .CORE_CLK              (CORE_CLK),
  .ARST_N                (ARST_N),
  .AVS_ADDRESS           (AVS_ADDRESS),
  .AVS_READ              (AVS_READ),
  .AVS_WRITE             (AVS_WRITE),
  .AVS_WRITEDATA         (AVS_WRITEDATA),
  .AVS_BYTEENABLE        (AVS_BYTEENABLE),
  .AVS_READDATA          (AVS_READDATA),
  .AVS_WAITREQUEST       (AVS_WAITREQUEST),
  .IRQ                   (IRQ),
  .WATCHDOG_NMI_REQUEST  (WATCHDOG_NMI_REQUEST),
  .WATCHDOG_SYSTEM_RESET (WATCHDOG_SYSTEM_RESET)
);

// ==== tb/wwd_top_tb_top.sv ====
// testbench: register, overflow, prewarning and window scenarios of the watchdog
`timescale 1ns/1ps
module wwd_top_tb_top
  import wwd_pkg::*;
;
  logic        CORE_CLK        = 1'b0;
  logic        ARST_N          = 1'b0;
  logic [4:0]  AVS_ADDRESS     = 5'h00;
  logic        AVS_READ        = 1'b0;
  logic        AVS_WRITE       = 1'b0;
  logic [31:0] AVS_WRITEDATA   = 32'h0000_0000;
  logic [3:0]  AVS_BYTEENABLE  = 4'hF;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        IRQ;
  logic        WATCHDOG_NMI_REQUEST;
  logic        WATCHDOG_SYSTEM_RESET;
  int          fails           = 0;
  int          n_checks        = 0;
  int          cyc             = 0;
  int          seed            = 32'h4e16c4f7;
  int          n;
  int          tn;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  string       q_nm[$];
  logic [31:0] me;
  logic [31:0] mm;
  string       mn;
  logic [4:0]  adr[9] = '{OFS_CTRL, OFS_RELOAD, OFS_WINDOW, OFS_SERVICE, OFS_COUNT,
                          OFS_STATUS, OFS_MASK, OFS_PREWARN, 5'h01};

  wwd_top wwd_top_i (
    .CORE_CLK              (CORE_CLK),
    .ARST_N                (ARST_N),
    .AVS_ADDRESS           (AVS_ADDRESS),
    .AVS_READ              (AVS_READ),
    .AVS_WRITE             (AVS_WRITE),
    .AVS_WRITEDATA         (AVS_WRITEDATA),
    .AVS_BYTEENABLE        (AVS_BYTEENABLE),
    .AVS_READDATA          (AVS_READDATA),
    .AVS_WAITREQUEST       (AVS_WAITREQUEST),
    .IRQ                   (IRQ),
    .WATCHDOG_NMI_REQUEST  (WATCHDOG_NMI_REQUEST),
    .WATCHDOG_SYSTEM_RESET (WATCHDOG_SYSTEM_RESET)
  );

  // ==========================================================================
  // clock, cycle count, read monitor
  // ==========================================================================
  always #25 CORE_CLK = ~CORE_CLK;
  // nonblocking so every reader at an edge sees the same count
  always @(posedge CORE_CLK) cyc <= cyc + 1;
  // takes the oldest note when read data is handed over
  always @(posedge CORE_CLK) begin
    if (AVS_READ && AVS_WAITREQUEST === 1'b0 && q_exp.size() > 0) begin
      me = q_exp.pop_front();
      mm = q_msk.pop_front();
      mn = q_nm.pop_front();
      n_checks++;
      if ((AVS_READDATA & mm) !== me) begin
        fails++;
        $display("mismatch %s expected %h seen %h", mn, me, AVS_READDATA & mm);
      end
    end
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  function automatic int period(input int sel, input int rel);
    return (2 ** (1 + sel * 6)) * (65536 - rel * 256);
  endfunction : period
  // one bus cycle; an idle edge first keeps back-to-back drives apart
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    // no cycle limit here: only the bench watchdog may end a hung wait
    do begin
      @(posedge CORE_CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] ex, input logic [31:0] mk,
                    input string nm);
    q_exp.push_back(ex);
    q_msk.push_back(mk);
    q_nm.push_back(nm);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic near(input string nm, input int ex, input int got, input int tol);
    n_checks++;
    if (got < ex - tol || got > ex + tol) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", nm, ex, got);
    end
  endtask : near
  task automatic flag(input string nm, input logic ex, input logic got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, ex, got);
    end
  endtask : flag
  // bounded wait for nmi (s=0) or system reset (s=1)
  task automatic waitfor(input logic s, output int k);
    int t0;
    t0 = cyc;
    while ((s ? WATCHDOG_SYSTEM_RESET : WATCHDOG_NMI_REQUEST) !== 1'b1 && cyc - t0 < 40000)
      @(posedge CORE_CLK);
    k = cyc - t0;
  endtask : waitfor
  task automatic rst();
    ARST_N <= 1'b0;
    repeat (16) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
  endtask : rst
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // ==========================================================================
  // watchdog and main sequence
  // ==========================================================================
  // longest path is the /128 run, about 39k clocks
  initial begin
    repeat (90000) @(posedge CORE_CLK);
    fails++;
    $display("bench timeout");
    summarize();
  end

  initial begin
    rst();
    foreach (adr[i]) rd(adr[i], 32'h0000_0000, 32'hFFFF_FFFF, "reset value");
    bus(1'b1, OFS_WINDOW, $random(seed));
    rd(OFS_WINDOW, {24'h00_0000, AVS_WRITEDATA[7:0]}, 32'hFFFF_FFFF, "window rw");
    bus(1'b1, OFS_COUNT, 32'h0000_1234);
    rd(OFS_COUNT, 32'h0000_0000, 32'hFFFF_FFFF, "count read only");
    AVS_BYTEENABLE <= 4'hE;
    bus(1'b1, OFS_RELOAD, 32'h0000_0011);
    AVS_BYTEENABLE <= 4'hF;
    rd(OFS_RELOAD, 32'h0000_0000, 32'hFFFF_FFFF, "lane0 off write");
    $display("test registers done");

    // overflow at /2, late service ignored, w1c clear
    bus(1'b1, OFS_RELOAD, 32'h0000_00FE);
    bus(1'b1, OFS_MASK, 32'h0000_0001);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    waitfor(1'b0, n);
    tn = cyc;
    near("overflow time div2", period(0, 'hFE), n, 4);
    bus(1'b1, OFS_SERVICE, $random(seed));
    rd(OFS_STATUS, 32'h0000_0005, 32'h0000_0007, "status overflow");
    flag("irq overflow", 1'b1, IRQ);
    bus(1'b1, OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0001, "status cleared");
    flag("irq cleared", 1'b0, IRQ);
    waitfor(1'b1, n);
    near("prewarning div2", 96, cyc - tn, 3);
    rd(OFS_STATUS, 32'h0000_000C, 32'h0000_000C, "status reset");
    $display("test overflow div2 done");

    // overflow at /128
    rst();
    bus(1'b1, OFS_RELOAD, 32'h0000_00FF);
    bus(1'b1, OFS_CTRL, 32'h0000_0003);
    waitfor(1'b0, n);
    tn = cyc;
    near("overflow time div128", period(1, 'hFF), n, 130);
    waitfor(1'b1, n);
    near("prewarning div128", 48 * 128, cyc - tn, 130);
    $display("test overflow div128 done");

    // valid service outside window, masked interrupt
    rst();
    bus(1'b1, OFS_RELOAD, 32'h0000_00F0);
    bus(1'b1, OFS_WINDOW, 32'h0000_00F1);
    bus(1'b1, OFS_CTRL, 32'h0000_0005);
    // window above reload: the count must pass F100h before a service is valid
    repeat (600) @(posedge CORE_CLK);
    bus(1'b1, OFS_SERVICE, $random(seed));
    tn = cyc;
    rd(OFS_COUNT, 32'h0000_F000, 32'hFFFF_FFF8, "count after service");
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0006, "late service valid");
    waitfor(1'b0, n);
    near("period after service", period(0, 'hF0), cyc - tn, 4);
    flag("irq masked", 1'b0, IRQ);
    $display("test valid service done");

    // service inside window
    rst();
    bus(1'b1, OFS_RELOAD, 32'h0000_00F0);
    bus(1'b1, OFS_WINDOW, 32'h0000_00F2);
    bus(1'b1, OFS_MASK, 32'h0000_0002);
    bus(1'b1, OFS_CTRL, 32'h0000_0005);
    repeat (20) @(posedge CORE_CLK);
    bus(1'b1, OFS_SERVICE, $random(seed));
    tn = cyc;
    rd(OFS_STATUS, 32'h0000_0006, 32'h0000_0007, "status invalid");
    flag("irq invalid", 1'b1, IRQ);
    waitfor(1'b1, n);
    near("prewarning invalid", 96, cyc - tn, 4);
    flag("nmi invalid", 1'b0, WATCHDOG_NMI_REQUEST);
    $display("test invalid service done");
    summarize();
  end
endmodule : wwd_top_tb_top
